// ### dpc_pkg.sv
// constants shared by the debug port clamp and security block
package dpc_pkg;
    // register byte offsets on the APB
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] SECURITY_OFFSET = 8'h08;
    // control register fields
    localparam int CTRL_TWO_WIRE_BIT = 0;
    localparam int CTRL_HALT_ARM_BIT = 1;
    localparam int CTRL_HALT_RELEASE_BIT = 2;
    // security register fields
    localparam int SEC_FLASH_BIT = 0;
    localparam int SEC_CHIP_ERASE_BIT = 1;
    // status register fields
    localparam int STAT_PRESENT_BIT = 0;
    localparam int STAT_HALTED_BIT = 1;
    localparam int STAT_PROTECTED_BIT = 2;
    localparam int STAT_STARTUP_BIT = 3;
    localparam int STAT_BUSY_BIT = 4;
    localparam int STAT_ERROR_BIT = 5;
    localparam int STAT_CLAMP_BIT = 6;
    localparam int STAT_TWO_WIRE_BIT = 7;
    // reset values
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic SEC_FLASH_RESET = 1'b0;
    // scan widths and instruction codes
    localparam int IR_WIDTH = 4;
    localparam int CHAIN_WIDTH = 8;
    localparam int STATUS_DR_WIDTH = 8;
    localparam logic [3:0] IR_CLAMP = 4'h5;
    localparam logic [3:0] IR_STATUS = 4'h7;
    localparam logic [3:0] IR_BYPASS = 4'hf;
    // test access port controller states
    typedef enum logic [3:0] {
        TAP_RESET = 4'b0000, TAP_IDLE = 4'b0001, TAP_SEL_DR = 4'b0010,
        TAP_CAP_DR = 4'b0011, TAP_SHIFT_DR = 4'b0100, TAP_EXIT1_DR = 4'b0101,
        TAP_PAUSE_DR = 4'b0110, TAP_EXIT2_DR = 4'b0111, TAP_UPD_DR = 4'b1000,
        TAP_SEL_IR = 4'b1001, TAP_CAP_IR = 4'b1010, TAP_SHIFT_IR = 4'b1011,
        TAP_EXIT1_IR = 4'b1100, TAP_PAUSE_IR = 4'b1101, TAP_EXIT2_IR = 4'b1110,
        TAP_UPD_IR = 4'b1111
    } dpc_tap_e;
endpackage

// ### dpc_debug_port.sv
// debugger detect filter, bus access lock and boundary-scan clamp tap
`timescale 1ns/1ps
`default_nettype none

// Operation
// RL1 - watch scan clock and reset pin, detect debugger attach, even hot-plug
// RL2 - on detection hand scan pins to the enhanced_debug_block
// RL3 - in two-wire mode give data-in and data-out pins back
// RL4 - when halt triggered, hold core in reset after external reset release
// RL5 - while protected, block every bus_access_port access
// RL6 - chip erase from debugger lifts protection and restores bus access
// RL7 - protected indication follows new security setting only after reset
// RL8 - all shift patterns move least significant bit first
// RL9 - startup-done bit reads one once start-up completed
// RL10 - error bit reads one after an error, zero otherwise
// RL11 - busy bit reads one when system_manager_access_port busy
// RL12 - debugger may shift anything into don't-care bits, ignores output
// RL13 - debugger may shift fewer bits than full register width
// RL14 - capture-IR loads protected, zero, zero, startup-done
// RL15 - CLAMP code 0101 selects one-bit bypass register
// RL16 - update-IR with CLAMP drives output pins from boundary chain
// RL17 - capture-DR under CLAMP loads zero into bypass
// RL18 - shift-DR under CLAMP moves data through single bypass stage
// RL19 - boundary-scan instruction register is four bits wide
module dpc_debug_port (
    // system clock and reset
    input wire logic clock,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // debugger link pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoOe,
    input wire logic extResetN,
    // system side
    input wire logic smapBusy,
    input wire logic smapError,
    input wire logic chipEraseCmd,
    input wire logic bapRequest,
    output logic bapGrant,
    output logic coreResetHold,
    output logic scanPinsToDebug,
    output logic dataPinsReleased,
    // boundary chain and functional outputs
    input wire logic [dpc_pkg::CHAIN_WIDTH-1:0] chainValue,
    input wire logic [dpc_pkg::CHAIN_WIDTH-1:0] funcOut,
    output logic [dpc_pkg::CHAIN_WIDTH-1:0] pinOut
);

    // ----------------------------------------------------------------
    // synchronisers into the system clock
    // ----------------------------------------------------------------
    logic [1:0] tckSync_reg;
    logic [1:0] resetNSync_reg;
    logic [1:0] eraseSync_reg;
    logic [1:0] clampSync_reg;
    logic tckLast_reg;
    logic eraseLast_reg;
    // clamp state lives on the scan clock, read here through the flag sync
    logic [dpc_pkg::CHAIN_WIDTH-1:0] clampValue_reg;
    logic clampActive_reg;

    // first stages feed only second stages
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tckSync_reg <= 2'h0;
            resetNSync_reg <= 2'h0;
            eraseSync_reg <= 2'h0;
            clampSync_reg <= 2'h0;
        end else begin
            tckSync_reg <= {tckSync_reg[0], tck};
            resetNSync_reg <= {resetNSync_reg[0], extResetN};
            eraseSync_reg <= {eraseSync_reg[0], chipEraseCmd};
            clampSync_reg <= {clampSync_reg[0], clampActive_reg};
        end
    end

    // edge history of synchronised levels
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tckLast_reg <= 1'b0;
            eraseLast_reg <= 1'b0;
        end else begin
            tckLast_reg <= tckSync_reg[1];
            eraseLast_reg <= eraseSync_reg[1];
        end
    end

    logic tckEdge;
    logic eraseEvent;
    logic extResetActive;
    assign tckEdge = tckSync_reg[1] ^ tckLast_reg;
    assign eraseEvent = eraseSync_reg[1] & ~eraseLast_reg;
    assign extResetActive = ~resetNSync_reg[1];

    // ----------------------------------------------------------------
    // apb register access
    // ----------------------------------------------------------------
    logic [2:0] ctrl_reg;
    logic flashSecure_reg;
    logic busWrite;
    logic busAccess;
    assign busAccess = psel & penable & pready;
    assign busWrite = busAccess & pwrite;

    // decode helper used by read and write paths
    function automatic logic isReg(input logic [31:0] addr, input logic [7:0] offset);
        isReg = (addr[31:8] == 24'h0) && (addr[7:0] == offset);
    endfunction

    // one wait state keeps pready a flip-flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    // control register; release bit is a self-clearing strobe
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_reg <= dpc_pkg::CTRL_RESET;
        end else if (busWrite && isReg(paddr, dpc_pkg::CTRL_OFFSET)) begin
            ctrl_reg <= pwdata[2:0];
        end else begin
            ctrl_reg[dpc_pkg::CTRL_HALT_RELEASE_BIT] <= 1'b0;
        end
    end

    // programmed flash security bit; any erase clears it
    // RL6 erase clears security
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flashSecure_reg <= dpc_pkg::SEC_FLASH_RESET;
        end else if (eraseEvent || (busWrite && isReg(paddr, dpc_pkg::SECURITY_OFFSET)
                     && pwdata[dpc_pkg::SEC_CHIP_ERASE_BIT])) begin
            flashSecure_reg <= 1'b0;
        end else if (busWrite && isReg(paddr, dpc_pkg::SECURITY_OFFSET)) begin
            flashSecure_reg <= pwdata[dpc_pkg::SEC_FLASH_BIT];
        end
    end

    // ----------------------------------------------------------------
    // protection state and start-up
    // ----------------------------------------------------------------
    logic protected_reg;
    logic startupDone_reg;
    logic eraseWrite;
    assign eraseWrite = busWrite && isReg(paddr, dpc_pkg::SECURITY_OFFSET)
                        && pwdata[dpc_pkg::SEC_CHIP_ERASE_BIT];

    // RL7 sampled only across a reset
    // the flag is not taken from the register under async reset; it
    // reloads while the external reset is held or on the first cycle after
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            protected_reg <= 1'b0;
        end else if (eraseEvent || eraseWrite) begin
            protected_reg <= 1'b0;
        end else if (!startupDone_reg || extResetActive) begin
            protected_reg <= flashSecure_reg;
        end
    end

    // RL9 startup done with the last reload, after reset release
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            startupDone_reg <= 1'b0;
        end else begin
            startupDone_reg <= ~extResetActive;
        end
    end

    // RL5 bus access gated by protection
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bapGrant <= 1'b0;
        end else begin
            bapGrant <= bapRequest & ~protected_reg;
        end
    end

    // ----------------------------------------------------------------
    // debugger detect filter and halt
    // ----------------------------------------------------------------
    logic halted_reg;

    // RL1 any scan clock edge means a probe
    // RL2 pins go to the debug block
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scanPinsToDebug <= 1'b0;
        end else if (tckEdge) begin
            scanPinsToDebug <= 1'b1;
        end
    end

    // RL3 two-wire mode frees data pins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dataPinsReleased <= 1'b0;
        end else begin
            dataPinsReleased <= scanPinsToDebug & ctrl_reg[dpc_pkg::CTRL_TWO_WIRE_BIT];
        end
    end

    // RL4 probe seen during reset arms the hold
    // set beats release so a late probe is not lost
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            halted_reg <= 1'b0;
        end else if (extResetActive && ctrl_reg[dpc_pkg::CTRL_HALT_ARM_BIT]
                     && (tckEdge || scanPinsToDebug)) begin
            halted_reg <= 1'b1;
        end else if (ctrl_reg[dpc_pkg::CTRL_HALT_RELEASE_BIT]) begin
            halted_reg <= 1'b0;
        end
    end

    // RL4 core reset outlives the pin
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            coreResetHold <= 1'b1;
        end else begin
            coreResetHold <= extResetActive | halted_reg;
        end
    end

    // RL16 pins follow the held chain
    // chain value was frozen on the tck edge that set the flag, two clock edges before the flag arrives
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pinOut <= '0;
        end else begin
            pinOut <= clampSync_reg[1] ? clampValue_reg : funcOut;
        end
    end

    // status read back
    logic [31:0] statusWord;
    always_comb begin
        statusWord = 32'h0;
        statusWord[dpc_pkg::STAT_PRESENT_BIT] = scanPinsToDebug;
        statusWord[dpc_pkg::STAT_HALTED_BIT] = halted_reg;
        statusWord[dpc_pkg::STAT_PROTECTED_BIT] = protected_reg;
        statusWord[dpc_pkg::STAT_STARTUP_BIT] = startupDone_reg;
        statusWord[dpc_pkg::STAT_BUSY_BIT] = smapBusy;
        statusWord[dpc_pkg::STAT_ERROR_BIT] = smapError;
        statusWord[dpc_pkg::STAT_CLAMP_BIT] = clampSync_reg[1];
        statusWord[dpc_pkg::STAT_TWO_WIRE_BIT] = dataPinsReleased;
    end

    // read data and error for unmapped addresses
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pslverr <= 1'b0;
            if (isReg(paddr, dpc_pkg::CTRL_OFFSET)) begin
                prdata <= {29'h0, ctrl_reg};
            end else if (isReg(paddr, dpc_pkg::STATUS_OFFSET)) begin
                prdata <= statusWord;
            end else if (isReg(paddr, dpc_pkg::SECURITY_OFFSET)) begin
                prdata <= {31'h0, flashSecure_reg};
            end else begin
                prdata <= 32'h0;
                pslverr <= 1'b1;
            end
        end else begin
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // boundary-scan access port on the scan clock
    // ----------------------------------------------------------------
    dpc_pkg::dpc_tap_e tapState_reg;
    dpc_pkg::dpc_tap_e tapState_next;
    logic [dpc_pkg::IR_WIDTH-1:0] irShift_reg;
    logic [dpc_pkg::IR_WIDTH-1:0] ir_reg;
    logic [dpc_pkg::STATUS_DR_WIDTH-1:0] drShift_reg;
    logic [1:0] protSync_reg;
    logic [1:0] startSync_reg;
    logic [1:0] busySync_reg;
    logic [1:0] errorSync_reg;

    // status levels into the scan clock
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            protSync_reg <= 2'h0;
            startSync_reg <= 2'h0;
            busySync_reg <= 2'h0;
            errorSync_reg <= 2'h0;
        end else begin
            protSync_reg <= {protSync_reg[0], protected_reg};
            startSync_reg <= {startSync_reg[0], startupDone_reg};
            busySync_reg <= {busySync_reg[0], smapBusy};
            errorSync_reg <= {errorSync_reg[0], smapError};
        end
    end

    // controller next state from tms
    always_comb begin
        case (tapState_reg)
            dpc_pkg::TAP_RESET: tapState_next = tms ? dpc_pkg::TAP_RESET : dpc_pkg::TAP_IDLE;
            dpc_pkg::TAP_IDLE: tapState_next = tms ? dpc_pkg::TAP_SEL_DR : dpc_pkg::TAP_IDLE;
            dpc_pkg::TAP_SEL_DR: tapState_next = tms ? dpc_pkg::TAP_SEL_IR : dpc_pkg::TAP_CAP_DR;
            dpc_pkg::TAP_CAP_DR,
            dpc_pkg::TAP_SHIFT_DR: tapState_next = tms ? dpc_pkg::TAP_EXIT1_DR : dpc_pkg::TAP_SHIFT_DR;
            dpc_pkg::TAP_EXIT1_DR: tapState_next = tms ? dpc_pkg::TAP_UPD_DR : dpc_pkg::TAP_PAUSE_DR;
            dpc_pkg::TAP_PAUSE_DR: tapState_next = tms ? dpc_pkg::TAP_EXIT2_DR : dpc_pkg::TAP_PAUSE_DR;
            dpc_pkg::TAP_EXIT2_DR: tapState_next = tms ? dpc_pkg::TAP_UPD_DR : dpc_pkg::TAP_SHIFT_DR;
            dpc_pkg::TAP_SEL_IR: tapState_next = tms ? dpc_pkg::TAP_RESET : dpc_pkg::TAP_CAP_IR;
            dpc_pkg::TAP_CAP_IR,
            dpc_pkg::TAP_SHIFT_IR: tapState_next = tms ? dpc_pkg::TAP_EXIT1_IR : dpc_pkg::TAP_SHIFT_IR;
            dpc_pkg::TAP_EXIT1_IR: tapState_next = tms ? dpc_pkg::TAP_UPD_IR : dpc_pkg::TAP_PAUSE_IR;
            dpc_pkg::TAP_PAUSE_IR: tapState_next = tms ? dpc_pkg::TAP_EXIT2_IR : dpc_pkg::TAP_PAUSE_IR;
            dpc_pkg::TAP_EXIT2_IR: tapState_next = tms ? dpc_pkg::TAP_UPD_IR : dpc_pkg::TAP_SHIFT_IR;
            default: tapState_next = tms ? dpc_pkg::TAP_SEL_DR : dpc_pkg::TAP_IDLE;
        endcase
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            tapState_reg <= dpc_pkg::TAP_RESET;
        end else begin
            tapState_reg <= tapState_next;
        end
    end

    // instruction shift path
    // RL19 four-bit instruction register
    // RL14 capture protected, zero, zero, startup
    // RL8 lsb leaves first, tdi enters at msb
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            irShift_reg <= '0;
        end else if (tapState_reg == dpc_pkg::TAP_CAP_IR) begin
            irShift_reg <= {startSync_reg[1], 2'b00, protSync_reg[1]};
        end else if (tapState_reg == dpc_pkg::TAP_SHIFT_IR) begin
            irShift_reg <= {tdi, irShift_reg[dpc_pkg::IR_WIDTH-1:1]};
        end
    end

    // RL15 clamp code picks bypass
    // RL16 clamp freezes chain at update
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            ir_reg <= dpc_pkg::IR_BYPASS;
            clampActive_reg <= 1'b0;
            clampValue_reg <= '0;
        end else if (tapState_reg == dpc_pkg::TAP_RESET) begin
            ir_reg <= dpc_pkg::IR_BYPASS;
            clampActive_reg <= 1'b0;
        end else if (tapState_reg == dpc_pkg::TAP_UPD_IR) begin
            ir_reg <= irShift_reg;
            clampActive_reg <= (irShift_reg == dpc_pkg::IR_CLAMP);
            if (irShift_reg == dpc_pkg::IR_CLAMP) begin
                clampValue_reg <= chainValue;
            end
        end
    end

    // data register: bypass stage or status word
    // RL17 bypass captures zero
    // RL9 RL10 RL11 status bits captured
    // RL18 one stage between tdi and tdo
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            drShift_reg <= '0;
        end else if (tapState_reg == dpc_pkg::TAP_CAP_DR) begin
            if (ir_reg == dpc_pkg::IR_STATUS) begin
                drShift_reg <= {4'h0, busySync_reg[1], errorSync_reg[1],
                                startSync_reg[1], protSync_reg[1]};
            end else begin
                drShift_reg <= '0;
            end
        end else if (tapState_reg == dpc_pkg::TAP_SHIFT_DR) begin
            if (ir_reg == dpc_pkg::IR_STATUS) begin
                drShift_reg <= {tdi, drShift_reg[dpc_pkg::STATUS_DR_WIDTH-1:1]};
            end else begin
                drShift_reg <= {7'h0, tdi};
            end
        end
    end

    // tdo changes on the falling edge so the probe samples it mid-bit
    always_ff @(negedge tck or posedge rst) begin
        if (rst) begin
            tdo <= 1'b0;
            tdoOe <= 1'b0;
        end else begin
            tdo <= (tapState_reg == dpc_pkg::TAP_SHIFT_IR) ? irShift_reg[0] : drShift_reg[0];
            tdoOe <= (tapState_reg == dpc_pkg::TAP_SHIFT_IR)
                     || (tapState_reg == dpc_pkg::TAP_SHIFT_DR);
        end
    end

endmodule

`default_nettype wire

// ### dpc_debug_port_asserts.sv
// checker for the debug port clamp and security block
`timescale 1ns/1ps
`default_nettype none
module dpc_debug_port_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // system side
    input wire logic extResetN,
    input wire logic bapRequest,
    input wire logic bapGrant,
    input wire logic coreResetHold,
    input wire logic scanPinsToDebug,
    input wire logic dataPinsReleased
);
    // everything here lives in the system clock domain
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    logic mapped;
    // decode of the three implemented words
    assign mapped = (paddr == {24'h0, dpc_pkg::CTRL_OFFSET})
        || (paddr == {24'h0, dpc_pkg::STATUS_OFFSET})
        || (paddr == {24'h0, dpc_pkg::SECURITY_OFFSET});
    // ----------------------------------------
    // register bus
    // ----------------------------------------
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready late");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access refused");
    // ----------------------------------------
    // pin handover, core reset hold and bus grant
    // ----------------------------------------
    a_scan_sticky: assert property (scanPinsToDebug |=> scanPinsToDebug)
        else $error("scan pins taken back");
    a_release_scan: assert property (dataPinsReleased |-> scanPinsToDebug)
        else $error("data pins released without debugger");
    a_hold_ext: assert property ((!extResetN) [*5] |-> coreResetHold)
        else $error("core not held during external reset");
    a_grant_req: assert property (bapGrant |-> $past(bapRequest))
        else $error("grant without request");
    a_grant_drop: assert property (!bapRequest |=> !bapGrant)
        else $error("grant kept after request dropped");
endmodule
bind dpc_debug_port dpc_debug_port_asserts chk_u (.clock(clock), .rst(rst),
    .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extResetN(extResetN), .bapRequest(bapRequest),
    .bapGrant(bapGrant), .coreResetHold(coreResetHold),
    .scanPinsToDebug(scanPinsToDebug), .dataPinsReleased(dataPinsReleased));
`default_nettype wire

// ### dpc_probe_model.sv
// debugger probe model driving the scan link
`timescale 1ns/1ps
`default_nettype none
module dpc_probe_model (
    // scan link towards the device
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // link clock parked low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // one 160 ns link cycle; tdo taken at the rising edge
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #80;
        tck = 1'b1;
        o = tdo;
        #80;
        tck = 1'b0;
    endtask
    // data line toggles when it carries nothing
    task automatic move(input logic m);
        logic o;
        step(m, ~tdi, o);
    endtask
    // five tms-high edges reach reset, then idle
    task automatic tapReset();
        repeat (5) move(1'b1);
        move(1'b0);
    endtask
    // lsb first, only n bits, then update and idle
    task automatic shift(input logic [7:0] v, input int n, output logic [7:0] q);
        logic o;
        q = 8'h00;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, v[i], o);
            q[i] = o;
        end
        move(1'b1);
        move(1'b0);
    endtask
    // instruction scan from idle
    task automatic irScan(input logic [7:0] v, input int n, output logic [7:0] q);
        move(1'b1);
        move(1'b1);
        move(1'b0);
        move(1'b0);
        shift(v, n, q);
    endtask
    // data scan from idle
    task automatic drScan(input logic [7:0] v, input int n, output logic [7:0] q);
        move(1'b1);
        move(1'b0);
        move(1'b0);
        shift(v, n, q);
    endtask
endmodule
`default_nettype wire

// ### test_debug_port_clamp_security.sv
// testbench for the debug port clamp and security block
`timescale 1ns/1ps
`default_nettype none
module test_debug_port_clamp_security;
    logic clock, rst, psel, penable, pwrite, pready, pslverr, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic tck, tms, tdi, tdo, tdoOe, extResetN, smapBusy, smapError;
    logic chipEraseCmd, bapRequest, bapGrant, coreResetHold;
    logic scanPinsToDebug, dataPinsReleased;
    logic [7:0] chainValue, funcOut, pinOut, q;
    int failures, checks;
    // ----------------------------------------
    // device and probe
    // ----------------------------------------
    dpc_debug_port dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdoOe(tdoOe), .extResetN(extResetN), .smapBusy(smapBusy),
        .smapError(smapError), .chipEraseCmd(chipEraseCmd), .bapRequest(bapRequest),
        .bapGrant(bapGrant), .coreResetHold(coreResetHold),
        .scanPinsToDebug(scanPinsToDebug), .dataPinsReleased(dataPinsReleased),
        .chainValue(chainValue), .funcOut(funcOut), .pinOut(pinOut));
    dpc_probe_model probe (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    // system clock, 8 ns
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; held until pready seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) chk(32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // watchdog, well beyond the expected run
    initial begin
        #400000;
        failures++;
        wrap_up();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {smapBusy, smapError, chipEraseCmd, bapRequest} = 4'h0;
        extResetN = 1'b1;
        chainValue = 8'ha5;
        funcOut = 8'h3c;
        failures = 0;
        checks = 0;
        rst = 1'b1;
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        apb(1'b0, dpc_pkg::CTRL_OFFSET, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, dpc_pkg::STATUS_OFFSET, 32'h0);
        chk(rd & 32'hcd, 32'h08);
        apb(1'b0, 8'h0c, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        // hot-plug while running takes the scan pins
        chk({31'h0, scanPinsToDebug}, 32'h0);
        probe.tapReset();
        repeat (4) @(posedge clock);
        chk({31'h0, scanPinsToDebug}, 32'h1);
        chk({24'h0, pinOut}, 32'h3c);
        // two-wire mode frees the data pins
        apb(1'b1, dpc_pkg::CTRL_OFFSET, 32'h1);
        repeat (3) @(posedge clock);
        chk({31'h0, dataPinsReleased}, 32'h1);
        apb(1'b1, dpc_pkg::CTRL_OFFSET, 32'h0);
        repeat (3) @(posedge clock);
        chk({31'h0, dataPinsReleased}, 32'h0);
        // busy and error flags, each alone
        for (int i = 0; i < 2; i++) begin
            smapBusy <= (i == 0);
            smapError <= (i == 1);
            repeat (4) @(posedge clock);
            apb(1'b0, dpc_pkg::STATUS_OFFSET, 32'h0);
            chk(rd & 32'h30, (i == 0) ? 32'h10 : 32'h20);
        end
        // new security value waits for a reset
        apb(1'b1, dpc_pkg::SECURITY_OFFSET, 32'h1);
        apb(1'b0, dpc_pkg::SECURITY_OFFSET, 32'h0);
        chk(rd, 32'h1);
        bapRequest <= 1'b1;
        apb(1'b0, dpc_pkg::STATUS_OFFSET, 32'h0);
        chk(rd & 32'h4, 32'h0);
        chk({31'h0, bapGrant}, 32'h1);
        // armed halt keeps the core in reset after the pin rises
        apb(1'b1, dpc_pkg::CTRL_OFFSET, 32'h2);
        extResetN <= 1'b0;
        repeat (10) @(posedge clock);
        extResetN <= 1'b1;
        repeat (10) @(posedge clock);
        chk({31'h0, coreResetHold}, 32'h1);
        apb(1'b0, dpc_pkg::STATUS_OFFSET, 32'h0);
        chk(rd & 32'h6, 32'h6);
        chk({31'h0, bapGrant}, 32'h0);
        apb(1'b1, dpc_pkg::CTRL_OFFSET, 32'h4);
        repeat (4) @(posedge clock);
        chk({31'h0, coreResetHold}, 32'h0);
        // clamp: capture pattern, frozen chain on the pins
        probe.irScan(8'h05, 4, q);
        chk({28'h0, q[3:0]}, 32'h9);
        repeat (6) @(posedge clock);
        chainValue <= 8'h0f;
        repeat (6) @(posedge clock);
        chk({24'h0, pinOut}, 32'ha5);
        apb(1'b0, dpc_pkg::STATUS_OFFSET, 32'h0);
        chk(rd & 32'h40, 32'h40);
        // bypass data scan of three bits only
        probe.drScan(8'h05, 3, q);
        chk({29'h0, q[2:0]}, 32'h2);
        // erase lifts the lock at once
        chipEraseCmd <= 1'b1;
        repeat (6) @(posedge clock);
        chk({31'h0, bapGrant}, 32'h1);
        apb(1'b0, dpc_pkg::STATUS_OFFSET, 32'h0);
        chk(rd & 32'h4, 32'h0);
        chipEraseCmd <= 1'b0;
        bapRequest <= 1'b0;
        // leaving clamp gives the pins back to the function
        probe.tapReset();
        repeat (6) @(posedge clock);
        chk({24'h0, pinOut}, 32'h3c);
        chk({31'h0, tdoOe}, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
